/* core/mrs_consts.svh */
// Purpose: constants for the reset sequencer
// Assumes: 20 MHz sys_clk
// Notes:   delay lengths are in clock cycles
`ifndef MRS_CONSTS_SVH
`define MRS_CONSTS_SVH

// ----------------------------------------
// start-up delay selection
// ----------------------------------------
`define MRS_SEL_W        4
`define MRS_DLY_W        20
// delay base in cycles per selector step (selector n gives (n+1) * base)
`define MRS_DLY_BASE     20'h00400
`define MRS_DLY_ZERO     20'h00000
`define MRS_DLY_ONE      20'h00001

// ----------------------------------------
// brown-out filter and level
// ----------------------------------------
`define MRS_BOD_MIN_NS   2000
`define MRS_CLK_NS       50
// minimum persistence rounds up to whole cycles
`define MRS_BOD_MIN_CYC  ((`MRS_BOD_MIN_NS + `MRS_CLK_NS - 1) / `MRS_CLK_NS)
`define MRS_BOD_CNT_W    8
`define MRS_LVL_W        3
`define MRS_LVL_OFF      3'h7
`define MRS_LVL_W2       8
`define MRS_HYST_HALF    8'h04
`define MRS_LVL_STEP     8'h10

// ----------------------------------------
// reset vector and port initial value
// ----------------------------------------
`define MRS_VEC_W        12
`define MRS_RESET_VEC    12'h000
`define MRS_PORT_W       4
`define MRS_PORT_INIT    4'h0

`endif

/* core/mrs_pkg.sv */
// Purpose: shared types for the reset sequencer
// Assumes: nothing
// Notes:   constants live in mrs_consts.svh
package mrs_pkg;
  typedef enum logic [1:0] {
    MRS_HOLD,
    MRS_STRETCH,
    MRS_RUN
  } mrs_state_t;
endpackage

/* core/mrs_brownout_filter.sv */
// Purpose: persistence filter and level compare for the brown-out detector
// Assumes: supplyCode is a synchronous digitised supply sample
// Notes:   hysteresis is applied around the fuse-chosen trigger level
`include "mrs_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module mrs_brownout_filter
  import mrs_pkg::*;
(
  // clock and reset
  input  wire logic                        sys_clk,
  input  wire logic                        rst_n,
  // configuration
  input  wire logic [`MRS_LVL_W-1:0]       brownoutLevelFuses,
  // supply sample
  input  wire logic [`MRS_LVL_W2-1:0]      supplyCode,
  // result
  output var  logic                        brownLow
);
  localparam logic [`MRS_BOD_CNT_W-1:0] MinCyc = `MRS_BOD_CNT_W'(`MRS_BOD_MIN_CYC);

  logic                       enabled;
  logic [`MRS_LVL_W2-1:0]     trigLevel;
  logic [`MRS_LVL_W2-1:0]     upperBound;
  logic [`MRS_LVL_W2-1:0]     lowerBound;
  logic                       belowLow;
  logic                       aboveHigh;
  logic [`MRS_BOD_CNT_W-1:0]  lowCnt_r;

  // ----------------------------------------
  // level and hysteresis window
  // ----------------------------------------
  // all-ones fuse code disables the detector
  assign enabled    = (brownoutLevelFuses != `MRS_LVL_OFF);
  assign trigLevel  = `MRS_LVL_W2'({5'h00, brownoutLevelFuses} * `MRS_LVL_STEP) + `MRS_LVL_STEP;
  assign upperBound = trigLevel + `MRS_HYST_HALF;
  assign lowerBound = trigLevel - `MRS_HYST_HALF;
  assign belowLow   = enabled && (supplyCode < lowerBound);
  assign aboveHigh  = !enabled || (supplyCode > upperBound);

  // count how long the supply has stayed low; short dips are ignored
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      lowCnt_r <= '0;
    end else if (!belowLow) begin
      lowCnt_r <= '0;
    end else if (lowCnt_r != MinCyc) begin
      lowCnt_r <= lowCnt_r + 1'b1;
    end
  end

  // flag once the drop has persisted; clear above the upper bound or when the detector is disabled
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      brownLow <= 1'b0;
    end else if (belowLow && lowCnt_r == MinCyc) begin
      brownLow <= 1'b1;
    end else if (aboveHigh) begin
      brownLow <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* core/mrs_reset_sequencer.sv */
// Purpose: combine reset sources and stretch the internal reset
// Assumes: sources are synchronous to sys_clk; rst_n is the test reset
// Notes:
`include "mrs_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module mrs_reset_sequencer
  import mrs_pkg::*;
(
  // clock and reset
  input  wire logic                        sys_clk,
  input  wire logic                        rst_n,
  // reset sources
  input  wire logic                        powerOnLow,
  input  wire logic                        extResetPin_n,
  input  wire logic                        extResetEnable,
  input  wire logic                        watchdogExpire,
  input  wire logic                        watchdogEnable,
  input  wire logic [`MRS_LVL_W2-1:0]      supplyCode,
  // fuses
  input  wire logic [`MRS_LVL_W-1:0]       brownoutLevelFuses,
  input  wire logic [1:0]                  startupTimeFuses,
  input  wire logic [1:0]                  clockSelectFuses,
  // port data from the core
  input  wire logic [`MRS_PORT_W-1:0]      portDataIn,
  // outputs
  output var  logic                        coreReset,
  output var  logic [`MRS_PORT_W-1:0]      portOut,
  output var  logic                        fetchStart,
  output var  logic [`MRS_VEC_W-1:0]       fetchAddr,
  output var  logic [3:0]                  causeActive
);
  mrs_state_t              state_r;
  mrs_state_t              state_nxt;
  logic                    brownLow;
  logic                    wdPulse_r;
  logic                    extActive;
  logic                    anySource;
  logic [3:0]              srcVec;
  logic [`MRS_DLY_W-1:0]   dlyCnt_r;
  logic [`MRS_DLY_W-1:0]   dlyLen;
  logic [`MRS_SEL_W-1:0]   dlySel;

  // ----------------------------------------
  // brown-out detector
  // ----------------------------------------
  mrs_brownout_filter uBod (
    .sys_clk            (sys_clk),
    .rst_n              (rst_n),
    .brownoutLevelFuses (brownoutLevelFuses),
    .supplyCode         (supplyCode),
    .brownLow           (brownLow)
  );

  // ----------------------------------------
  // source gathering
  // ----------------------------------------
  // the pin counts only with its reset function on; level-sensitive, so it
  // needs no edge and holds as long as the pulse does
  assign extActive = extResetEnable && !extResetPin_n;

  // watchdog expiry becomes a single-cycle pulse, gated by its enable
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wdPulse_r <= 1'b0;
    end else begin
      wdPulse_r <= watchdogEnable && watchdogExpire && !wdPulse_r && state_r == MRS_RUN;
    end
  end

  // four causes, ORed into one request
  assign srcVec    = {brownLow, wdPulse_r, extActive, powerOnLow};
  assign anySource = |srcVec;

  // ----------------------------------------
  // delay length from fuses
  // ----------------------------------------
  assign dlySel = {startupTimeFuses, clockSelectFuses};
  assign dlyLen = `MRS_DLY_W'((`MRS_DLY_W'(dlySel) + `MRS_DLY_ONE) * `MRS_DLY_BASE);

  // ----------------------------------------
  // sequencing state machine
  // ----------------------------------------
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      MRS_HOLD: begin
        if (!anySource) begin
          state_nxt = MRS_STRETCH;
        end
      end
      MRS_STRETCH: begin
        if (anySource) begin
          state_nxt = MRS_HOLD;
        end else if (dlyCnt_r == `MRS_DLY_ONE) begin
          state_nxt = MRS_RUN;
        end
      end
      MRS_RUN: begin
        if (anySource) begin
          state_nxt = MRS_HOLD;
        end
      end
      default: begin
        state_nxt = MRS_HOLD;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_r <= MRS_HOLD;
    end else begin
      state_r <= state_nxt;
    end
  end

  // delay counter loads on release and restarts on any reassertion
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      dlyCnt_r <= `MRS_DLY_ZERO;
    end else if (anySource || state_r == MRS_HOLD) begin
      dlyCnt_r <= dlyLen;
    end else if (state_r == MRS_STRETCH && dlyCnt_r != `MRS_DLY_ZERO) begin
      dlyCnt_r <= dlyCnt_r - `MRS_DLY_ONE;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // reset is held in every state but run, and asserted on the clock edge after a
  // source is seen, the same edge on which the state returns to hold
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      coreReset <= 1'b1;
    end else begin
      coreReset <= anySource || state_nxt != MRS_RUN;
    end
  end

  // ports forced to initial state whenever reset is active; the core's data
  // flows only while running
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      portOut <= `MRS_PORT_INIT;
    end else if (anySource || state_nxt != MRS_RUN) begin
      portOut <= `MRS_PORT_INIT;
    end else begin
      portOut <= portDataIn;
    end
  end

  // single pulse on entry to run; fetch starts from the reset vector,
  // where software is expected to place a relative jump
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      fetchStart <= 1'b0;
      fetchAddr  <= `MRS_RESET_VEC;
    end else begin
      fetchStart <= (state_r == MRS_STRETCH) && (state_nxt == MRS_RUN);
      fetchAddr  <= `MRS_RESET_VEC;
    end
  end

  // live view of which causes are asserted
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      causeActive <= 4'h0;
    end else begin
      causeActive <= srcVec;
    end
  end
endmodule
`default_nettype wire

/* sim/mrs_props.sv */
// Purpose: port checker for the reset sequencer
// Assumes: one clock, rst_n synchronous active low
// Notes:   stretch floor is 1000 cycles, just under the shortest selector delay
`include "mrs_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module mrs_props
  import mrs_pkg::*;
(
  // clock, reset and sources
  input wire logic sys_clk, rst_n, powerOnLow, extResetPin_n, extResetEnable,
  input wire logic watchdogExpire, watchdogEnable,
  input wire logic [`MRS_LVL_W2-1:0] supplyCode,
  // fuses and core data
  input wire logic [`MRS_LVL_W-1:0] brownoutLevelFuses,
  input wire logic [1:0] startupTimeFuses, clockSelectFuses,
  input wire logic [`MRS_PORT_W-1:0] portDataIn,
  // outputs under check
  input wire logic coreReset, fetchStart,
  input wire logic [`MRS_PORT_W-1:0] portOut,
  input wire logic [`MRS_VEC_W-1:0] fetchAddr,
  input wire logic [3:0] causeActive
);
  // -------------------------------
  // stretch length counter
  // -------------------------------
  logic [10:0] holdCnt_r;
  // saturates, so long holds never wrap into a false short one
  always_ff @(posedge sys_clk) begin
    if (!rst_n || !coreReset) holdCnt_r <= 11'h000;
    else if (holdCnt_r != 11'h7ff) holdCnt_r <= holdCnt_r + 11'h001;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  property p_port; coreReset |-> portOut == `MRS_PORT_INIT; endproperty
  property p_vec; fetchStart |-> fetchAddr == `MRS_RESET_VEC && !coreReset; endproperty
  property p_por; powerOnLow |=> coreReset; endproperty
  property p_ext; !extResetPin_n && extResetEnable |=> coreReset; endproperty
  property p_wd; watchdogExpire && watchdogEnable && !coreReset |-> ##[1:3] coreReset; endproperty
  property p_wdpulse; $rose(causeActive[2]) |=> !causeActive[2]; endproperty
  property p_stretch; $fell(coreReset) |-> holdCnt_r >= 11'd1000; endproperty
  property p_fetch; $fell(coreReset) |-> fetchStart; endproperty
  property p_cause; powerOnLow |-> ##[1:2] causeActive[0]; endproperty
  a_port: assert property (p_port) else $error("port not initial in reset");
  a_vec: assert property (p_vec) else $error("bad fetch address");
  a_por: assert property (p_por) else $error("power-on low not in reset");
  a_ext: assert property (p_ext) else $error("pin low not in reset");
  a_wd: assert property (p_wd) else $error("watchdog expiry ignored");
  a_wdpulse: assert property (p_wdpulse) else $error("watchdog pulse too long");
  a_stretch: assert property (p_stretch) else $error("stretch too short");
  a_fetch: assert property (p_fetch) else $error("no fetch at release");
  a_cause: assert property (p_cause) else $error("power-on cause missing");
  c_fetch: cover property (fetchStart);
  c_brown: cover property ($rose(causeActive[3]));
  c_wd: cover property ($rose(causeActive[2]));
endmodule
bind mrs_reset_sequencer mrs_props mrs_props_i (.sys_clk(sys_clk), .rst_n(rst_n), .powerOnLow(powerOnLow),
  .extResetPin_n(extResetPin_n), .extResetEnable(extResetEnable), .watchdogExpire(watchdogExpire),
  .watchdogEnable(watchdogEnable), .supplyCode(supplyCode), .brownoutLevelFuses(brownoutLevelFuses),
  .startupTimeFuses(startupTimeFuses), .clockSelectFuses(clockSelectFuses), .portDataIn(portDataIn),
  .coreReset(coreReset), .fetchStart(fetchStart), .portOut(portOut), .fetchAddr(fetchAddr),
  .causeActive(causeActive));
`default_nettype wire

/* sim/mrs_supply_model.sv */
// Purpose: supply monitor and reset pin driver model
// Assumes: requests come from the bench after a clock edge
// Notes:   power-on detect follows the supply sample
`timescale 1ns/10ps
`default_nettype none
module mrs_supply_model
  import mrs_pkg::*;
#(
  parameter logic [7:0] PowerOnThreshold = 8'h08,
  parameter logic [3:0] PinMinCycles     = 4'h4
)(
  // requests
  input  wire logic       sys_clk,
  input  wire logic       pinReq,
  input  wire logic [7:0] supplyReq,
  // monitor and pin outputs
  output var  logic       powerOnLow,
  output var  logic       extResetPin_n,
  output var  logic [7:0] supplyCode
);
  logic [3:0] lowCnt_r = 4'h0;
  initial {powerOnLow, extResetPin_n, supplyCode} = {1'b0, 1'b1, 8'hc8};
  // a pin pulse is always held for at least the minimum width
  always @(posedge sys_clk) begin
    supplyCode <= #1 supplyReq;
    powerOnLow <= #1 (supplyReq < PowerOnThreshold);
    lowCnt_r <= pinReq ? PinMinCycles : (lowCnt_r != 4'h0 ? lowCnt_r - 4'h1 : 4'h0);
    extResetPin_n <= #1 !(pinReq || lowCnt_r > 4'h1);
  end
endmodule
`default_nettype wire

/* sim/tb_top.sv */
// Purpose: self-checking bench for the reset sequencer
// Assumes: 20 MHz clock, inputs change 1 ns after the rising edge
// Notes:   stretch windows allow a few cycles of pipeline slack
`include "mrs_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module tb_top import mrs_pkg::*;;
  logic sys_clk = 1'b0, rst_n = 1'b0, pinReq = 1'b0, extResetEnable = 1'b1;
  logic watchdogExpire = 1'b0, watchdogEnable = 1'b0, powerOnLow, extResetPin_n, coreReset, fetchStart;
  logic [7:0] supplyReq = 8'hc8, supplyCode;
  logic [2:0] brownoutLevelFuses = 3'h7;
  logic [1:0] startupTimeFuses = 2'h0, clockSelectFuses = 2'h0;
  logic [3:0] portDataIn = 4'ha, portOut, causeActive;
  logic [11:0] fetchAddr;
  int n_mismatch = 0, n_checks = 0;
  always #25 sys_clk = ~sys_clk;
  mrs_supply_model mrs_supply_model_i (.sys_clk(sys_clk), .pinReq(pinReq), .supplyReq(supplyReq),
    .powerOnLow(powerOnLow), .extResetPin_n(extResetPin_n), .supplyCode(supplyCode));
  mrs_reset_sequencer mrs_reset_sequencer_i (.sys_clk(sys_clk), .rst_n(rst_n), .powerOnLow(powerOnLow),
    .extResetPin_n(extResetPin_n), .extResetEnable(extResetEnable), .watchdogExpire(watchdogExpire),
    .watchdogEnable(watchdogEnable), .supplyCode(supplyCode), .brownoutLevelFuses(brownoutLevelFuses),
    .startupTimeFuses(startupTimeFuses), .clockSelectFuses(clockSelectFuses), .portDataIn(portDataIn),
    .coreReset(coreReset), .portOut(portOut), .fetchStart(fetchStart), .fetchAddr(fetchAddr),
    .causeActive(causeActive));
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic check(input string nm, input logic [11:0] seen, input logic [11:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cr(input logic e);
    check("coreReset", {11'h0, coreReset}, {11'h0, e});
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // bounded wait for release; length compared with the selected delay
  task automatic rel(input int exp);
    int n;
    n = 0;
    while (fetchStart !== 1'b1) begin
      @(posedge sys_clk);
      #2;
      n++;
      if (n > exp + 40) begin
        n_mismatch++;
        complete_run;
      end
    end
    check("fetchAddr", fetchAddr, `MRS_RESET_VEC);
    check("stretch", {11'h0, n >= exp - 4 && n <= exp + 6}, 12'h1);
    step(2);
    check("portOut", {8'h0, portOut}, {8'h0, portDataIn});
  endtask
  // -------------------------------
  // test sequence
  // -------------------------------
  initial begin
    step(4);
    rst_n = 1'b1;
    rel(1024);
    $display("test power-up done");
    extResetEnable = 1'b0;
    pinReq = 1'b1;
    step(1);
    pinReq = 1'b0;
    step(8);
    cr(1'b0);
    {extResetEnable, clockSelectFuses, pinReq} = {1'b1, 2'h1, 1'b1};
    step(1);
    pinReq = 1'b0;
    step(2);
    cr(1'b1);
    check("portOut", {8'h0, portOut}, 12'h0);
    check("causeActive", {8'h0, causeActive}, 12'h002);
    rel(2050);
    $display("test pin done");
    clockSelectFuses = 2'h0;
    supplyReq = 8'h04;
    step(5);
    cr(1'b1);
    check("causeActive", {8'h0, causeActive}, 12'h001);
    supplyReq = 8'hc8;
    step(500);
    cr(1'b1);
    supplyReq = 8'h04;
    step(1);
    supplyReq = 8'hc8;
    step(3);
    cr(1'b1);
    rel(1022);
    $display("test power-on done");
    {brownoutLevelFuses, supplyReq} = {3'h0, 8'h0a};
    step(20);
    supplyReq = 8'hc8;
    step(60);
    cr(1'b0);
    supplyReq = 8'h0a;
    step(50);
    cr(1'b1);
    supplyReq = 8'h12;
    step(100);
    cr(1'b1);
    supplyReq = 8'hc8;
    rel(1026);
    {brownoutLevelFuses, supplyReq} = {3'h7, 8'h0a};
    step(60);
    cr(1'b0);
    supplyReq = 8'hc8;
    step(2);
    $display("test brown-out done");
    watchdogExpire = 1'b1;
    step(1);
    watchdogExpire = 1'b0;
    step(4);
    cr(1'b0);
    {watchdogEnable, watchdogExpire} = 2'b11;
    step(1);
    watchdogExpire = 1'b0;
    step(3);
    cr(1'b1);
    rel(1022);
    $display("test watchdog done");
    complete_run;
  end
endmodule
`default_nettype wire
